// *** core/nvsc_pkg.sv ***
// shared constants and types for the nonvolatile sram sequence controller
package nvsc_pkg;

  localparam int          ADDR_W     = 15;
  localparam int          DATA_W     = 8;
  localparam int          SEQ_LEN    = 6;
  // match uses address bits 14..2 only
  localparam int          MATCH_LSB  = 2;

  localparam logic [14:0] SEQ_A0     = 15'h0E38;
  localparam logic [14:0] SEQ_A1     = 15'h31C7;
  localparam logic [14:0] SEQ_A2     = 15'h03E0;
  localparam logic [14:0] SEQ_A3     = 15'h3C1F;
  localparam logic [14:0] SEQ_A4     = 15'h303F;
  localparam logic [14:0] SEQ_SAVE   = 15'h0FC0;
  localparam logic [14:0] SEQ_REST   = 15'h0C63;
  localparam logic [14:0] SEQ_PLS_OFF = 15'h0B45;
  localparam logic [14:0] SEQ_PLS_ON = 15'h0B46;

  localparam int          CLK_MHZ    = 25;
  // access phase lengths in ns
  localparam int          T_SETUP_NS = 40;
  localparam int          T_STROBE_NS = 80;
  localparam int          T_GAP_NS   = 40;
  localparam int          SETUP_CYC  = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int          STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int          GAP_CYC    = (T_GAP_NS * CLK_MHZ + 999) / 1000;
  // time after busy release before access, ns
  localparam int          T_RELEASE_NS = 20;
  localparam int          RELEASE_CYC = (T_RELEASE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    NVSC_CMD_READ     = 3'h0,
    NVSC_CMD_WRITE    = 3'h1,
    NVSC_CMD_SAVE     = 3'h2,
    NVSC_CMD_RESTORE  = 3'h3,
    NVSC_CMD_PLS_OFF  = 3'h4,
    NVSC_CMD_PLS_ON   = 3'h5
  } nvsc_cmd_e;

  typedef struct packed {
    nvsc_cmd_e         cmd;
    logic [14:0]       addr;
    logic [7:0]        wdata;
  } nvsc_req_s;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [14:0]       addr;
  } nvsc_bus_s;

endpackage

// *** core/nvsc_host.sv ***
// host side controller issuing sram accesses and nonvolatile command sequences
`timescale 1ns/1ps
//
// Contract
// [RULE_01] device latches restore at power-up/low supply
// [RULE_02] power-up restore holds busy low
// [RULE_03] save: six reads at fixed addresses
// [RULE_04] intervening access aborts the sequence
// [RULE_05] save erases then programs nonvolatile cells
// [RULE_06] save: busy low until cycle done
// [RULE_07] host keeps write strobe high
// [RULE_08] restore: five common, sixth 0x0C63
// [RULE_09] restore clears then copies to ram
// [RULE_10] ram usable after restore time
// [RULE_11] only address bits 14..2 match; the device model compares the full address for the two setting codes
// [RULE_12] sixth read 0x0B45 disables power-loss save
// [RULE_13] sixth read 0x0B46 enables power-loss save
// [RULE_14] host follows setting change with save; controller only raises pls_change_pending, issues no save
// [RULE_15] delivered with power-loss save enabled
// [RULE_16] low supply blocks saves and writes
// [RULE_17] write suppressed until busy release time
// [RULE_18] low io supply disables ios
// [RULE_19] sixth save/restore read leaves data hi-z
// [RULE_20] auto saves skipped without prior write
// [RULE_21] busy low for whole save
// [RULE_22] ram inhibited during save or restore
// [RULE_23] first five reads return ram data
// [RULE_24] bad address restarts sequence detection
module nvsc_host #(
  parameter int SEQ_GAP = nvsc_pkg::GAP_CYC
) (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                req_valid,
  input  wire nvsc_pkg::nvsc_req_s req,
  output logic                     req_ready,
  output logic                     rsp_valid,
  output logic [7:0]               rsp_rdata,
  output logic                     pls_change_pending,
  output logic                     ce_n,
  output logic                     oe_n,
  output logic                     we_n,
  output logic [14:0]              addr,
  output logic [7:0]               dq_out,
  output logic                     dq_oe,
  input  wire logic [7:0]          dq_in,
  input  wire logic                store_busy_n_in
);

  // the gap counter is four bits wide
  if (SEQ_GAP < 1 || SEQ_GAP > 15) begin : g_gap_check
    $error("SEQ_GAP must be 1 to 15 cycles");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic       busy_s1;
  logic       busy_s2;
  logic [7:0] dq_s1;
  logic [7:0] dq_s2;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      dq_s1   <= 8'h00;
      dq_s2   <= 8'h00;
    end else begin
      busy_s1 <= store_busy_n_in;
      busy_s2 <= busy_s1;
      dq_s1   <= dq_in;
      dq_s2   <= dq_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access sequencer

  typedef enum logic [2:0] {
    NVSC_IDLE   = 3'b000,
    NVSC_WAIT   = 3'b001,
    NVSC_SETUP  = 3'b011,
    NVSC_STROBE = 3'b010,
    NVSC_GAP    = 3'b110,
    NVSC_DONE   = 3'b111
  } nvsc_state_e;

  nvsc_state_e         state;
  nvsc_state_e         next_state;
  nvsc_pkg::nvsc_req_s cur;
  nvsc_pkg::nvsc_req_s next_cur;
  logic [2:0]          step;
  logic [2:0]          next_step;
  logic [3:0]          cnt;
  logic [3:0]          next_cnt;
  logic [7:0]          rdata;
  logic [7:0]          next_rdata;
  logic                next_rsp_valid;
  logic                next_req_ready;
  logic                next_pls;
  logic                next_ce_n;
  logic                next_oe_n;
  logic                next_we_n;
  logic [14:0]         next_addr;
  logic [7:0]          next_dq_out;
  logic                next_dq_oe;
  logic                is_seq;
  logic                last_step;
  logic [14:0]         step_addr;

  // data synchroniser depth; the strobe is stretched so the sample has settled
  localparam int SYNC_CYC = 2;

  assign is_seq    = (cur.cmd != nvsc_pkg::NVSC_CMD_READ) && (cur.cmd != nvsc_pkg::NVSC_CMD_WRITE);
  assign last_step = !is_seq || (step == 3'(nvsc_pkg::SEQ_LEN - 1));

  // [RULE_03] sequence address list
  always_comb begin
    case (step)
      3'h0:    step_addr = nvsc_pkg::SEQ_A0;
      3'h1:    step_addr = nvsc_pkg::SEQ_A1;
      3'h2:    step_addr = nvsc_pkg::SEQ_A2;
      3'h3:    step_addr = nvsc_pkg::SEQ_A3;
      3'h4:    step_addr = nvsc_pkg::SEQ_A4;
      default: begin
        // [RULE_08] sixth read selects command
        case (cur.cmd)
          nvsc_pkg::NVSC_CMD_SAVE:    step_addr = nvsc_pkg::SEQ_SAVE;
          nvsc_pkg::NVSC_CMD_RESTORE: step_addr = nvsc_pkg::SEQ_REST;
          // [RULE_12] disable code
          nvsc_pkg::NVSC_CMD_PLS_OFF: step_addr = nvsc_pkg::SEQ_PLS_OFF;
          // [RULE_13] enable code
          default:                    step_addr = nvsc_pkg::SEQ_PLS_ON;
        endcase
      end
    endcase
  end

  always_comb begin
    next_state     = state;
    next_cur       = cur;
    next_step      = step;
    next_cnt       = cnt;
    next_rdata     = rdata;
    next_rsp_valid = 1'b0;
    next_req_ready = 1'b0;
    next_pls       = pls_change_pending;
    next_ce_n      = 1'b1;
    next_oe_n      = 1'b1;
    next_we_n      = 1'b1;
    next_addr      = addr;
    next_dq_out    = dq_out;
    next_dq_oe     = 1'b0;
    case (state)
      NVSC_IDLE: begin
        next_req_ready = 1'b1;
        if (req_valid && req_ready) begin
          next_cur       = req;
          next_step      = 3'h0;
          next_req_ready = 1'b0;
          next_state     = NVSC_WAIT;
        end
      end
      // [RULE_22] never access while busy
      NVSC_WAIT: begin
        if (!busy_s2) begin
          next_cnt = 4'(nvsc_pkg::RELEASE_CYC);
        end else if (cnt != 4'h0) begin
          next_cnt = cnt - 4'h1;
        end else begin
          next_cnt   = 4'(nvsc_pkg::SETUP_CYC);
          next_state = NVSC_SETUP;
        end
      end
      NVSC_SETUP: begin
        next_ce_n   = 1'b0;
        next_addr   = is_seq ? step_addr : cur.addr;
        next_dq_out = cur.wdata;
        if (cnt <= 4'h1) begin
          next_cnt   = 4'(nvsc_pkg::STROBE_CYC + SYNC_CYC);
          next_state = NVSC_STROBE;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      NVSC_STROBE: begin
        next_ce_n = 1'b0;
        // [RULE_07] we high during sequences
        if (cur.cmd == nvsc_pkg::NVSC_CMD_WRITE) begin
          next_we_n  = 1'b0;
          next_dq_oe = 1'b1;
        end else begin
          next_oe_n = 1'b0;
        end
        if (cnt <= 4'h1) begin
          // sample registered three edges after the gate fell, past the synchroniser
          next_rdata = dq_s2;
          next_cnt   = 4'(SEQ_GAP);
          next_we_n  = 1'b1;
          next_oe_n  = 1'b1;
          // write data stays driven one more cycle so the strobe edge has hold time
          next_state = NVSC_GAP;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      // [RULE_04] reads back to back, nothing intervenes
      NVSC_GAP: begin
        if (cnt <= 4'h1) begin
          if (last_step) begin
            next_state = NVSC_DONE;
          end else begin
            next_step  = step + 3'h1;
            next_cnt   = 4'(nvsc_pkg::SETUP_CYC);
            next_state = NVSC_SETUP;
          end
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      NVSC_DONE: begin
        next_rsp_valid = 1'b1;
        // [RULE_14] flag setting change until saved
        if (cur.cmd == nvsc_pkg::NVSC_CMD_PLS_OFF || cur.cmd == nvsc_pkg::NVSC_CMD_PLS_ON) begin
          next_pls = 1'b1;
        end else if (cur.cmd == nvsc_pkg::NVSC_CMD_SAVE) begin
          next_pls = 1'b0;
        end
        next_cnt       = 4'(nvsc_pkg::RELEASE_CYC);
        next_req_ready = 1'b1;
        next_state     = NVSC_IDLE;
      end
      default: next_state = NVSC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state              <= NVSC_IDLE;
      cur                <= '0;
      step               <= 3'h0;
      cnt                <= 4'h0;
      rdata              <= 8'h00;
      rsp_valid          <= 1'b0;
      req_ready          <= 1'b0;
      pls_change_pending <= 1'b0;
      ce_n               <= 1'b1;
      oe_n               <= 1'b1;
      we_n               <= 1'b1;
      addr               <= 15'h0000;
      dq_out             <= 8'h00;
      dq_oe              <= 1'b0;
    end else begin
      state              <= next_state;
      cur                <= next_cur;
      step               <= next_step;
      cnt                <= next_cnt;
      rdata              <= next_rdata;
      rsp_valid          <= next_rsp_valid;
      req_ready          <= next_req_ready;
      pls_change_pending <= next_pls;
      ce_n               <= next_ce_n;
      oe_n               <= next_oe_n;
      we_n               <= next_we_n;
      addr               <= next_addr;
      dq_out             <= next_dq_out;
      dq_oe              <= next_dq_oe;
    end
  end

  assign rsp_rdata = rdata;

endmodule

// *** dv/nvsc_host_properties.sv ***
// concurrent checks on the host controller ports
`timescale 1ns/1ps
module nvsc_host_properties (
  input wire logic                clk,
  input wire logic                arst_n,
  input wire logic                req_valid,
  input wire nvsc_pkg::nvsc_req_s req,
  input wire logic                req_ready,
  input wire logic                rsp_valid,
  input wire logic                pls_change_pending,
  input wire logic                ce_n,
  input wire logic                oe_n,
  input wire logic                we_n,
  input wire logic [14:0]         addr,
  input wire logic                dq_oe,
  input wire logic                store_busy_n_in
);
  logic [2:0]          cnt;
  logic [2:0]          next_cnt;
  logic                ce_q;
  logic [14:0]         exp_a;
  nvsc_pkg::nvsc_cmd_e cur;
  nvsc_pkg::nvsc_cmd_e next_cur;
  wire                 fall = ce_q && !ce_n;
  wire                 seq  = cur >= nvsc_pkg::NVSC_CMD_SAVE;
  always_comb begin
    next_cnt = cnt;
    next_cur = cur;
    if (req_valid && req_ready) begin
      next_cur = req.cmd;
      next_cnt = 3'h0;
    end else if (fall && cnt != 3'h7) begin
      next_cnt = cnt + 3'h1;
    end
    case (cnt)
      3'h0: exp_a = nvsc_pkg::SEQ_A0;
      3'h1: exp_a = nvsc_pkg::SEQ_A1;
      3'h2: exp_a = nvsc_pkg::SEQ_A2;
      3'h3: exp_a = nvsc_pkg::SEQ_A3;
      3'h4: exp_a = nvsc_pkg::SEQ_A4;
      default: exp_a = cur == nvsc_pkg::NVSC_CMD_SAVE ? nvsc_pkg::SEQ_SAVE :
                       cur == nvsc_pkg::NVSC_CMD_RESTORE ? nvsc_pkg::SEQ_REST :
                       cur == nvsc_pkg::NVSC_CMD_PLS_OFF ? nvsc_pkg::SEQ_PLS_OFF :
                       nvsc_pkg::SEQ_PLS_ON;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 3'h0;
      cur <= nvsc_pkg::NVSC_CMD_READ;
      ce_q <= 1'b1;
    end else begin
      cnt <= next_cnt;
      cur <= next_cur;
      ce_q <= ce_n;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  seq_addr_a: assert property (fall && seq |-> addr == exp_a)
    else $error("sequence address out of order");
  seq_we_high_a: assert property (seq && !ce_n |-> we_n)
    else $error("write strobe low inside a sequence");
  read_select_a: assert property (!oe_n |-> !ce_n && we_n)
    else $error("output gate without select or with write");
  no_contend_a: assert property (dq_oe |-> oe_n)
    else $error("host drives data while gating output");
  rsp_ready_a: assert property (rsp_valid |-> req_ready ##1 !rsp_valid)
    else $error("response not a pulse followed by ready");
  pls_set_a: assert property (rsp_valid && cur >= nvsc_pkg::NVSC_CMD_PLS_OFF
    |-> ##[0:1] pls_change_pending)
    else $error("setting change not flagged");
  pls_clr_a: assert property (rsp_valid && cur == nvsc_pkg::NVSC_CMD_SAVE
    |-> ##[0:1] !pls_change_pending)
    else $error("save did not clear setting flag");
  busy_wait_a: assert property (fall |-> $past(store_busy_n_in, 3))
    else $error("access started while device busy");
  cover property (rsp_valid && cur == nvsc_pkg::NVSC_CMD_SAVE);
  cover property (rsp_valid && cur == nvsc_pkg::NVSC_CMD_RESTORE);
  cover property (rsp_valid && cur == nvsc_pkg::NVSC_CMD_PLS_OFF);
endmodule
bind nvsc_host nvsc_host_properties u_props (.clk(clk), .arst_n(arst_n),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .pls_change_pending(pls_change_pending), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
  .addr(addr), .dq_oe(dq_oe), .store_busy_n_in(store_busy_n_in));

// *** dv/nvsc_dev_model.sv ***
// behavioural model of the nonvolatile sram device
`timescale 1ns/1ps
module nvsc_dev_model #(
  parameter int T_SAVE = 2000,
  parameter int T_REST = 800
) (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [14:0] addr,
  input  wire logic [7:0]  din,
  output logic [7:0]       dout,
  output logic             busy_n,
  output logic             pls_en
);
  logic [7:0]  sram [0:32767];
  logic [7:0]  nv   [0:32767];
  logic [2:0]  idx = 3'h0;
  logic [1:0]  pend = 2'h0;
  logic [12:0] m;
  // io supply level; this bench runs no brown-out, so it stays on
  logic        io_on = 1'b1;
  function automatic logic [12:0] sq(input logic [2:0] i);
    case (i)
      3'h0: return nvsc_pkg::SEQ_A0[14:2];
      3'h1: return nvsc_pkg::SEQ_A1[14:2];
      3'h2: return nvsc_pkg::SEQ_A2[14:2];
      3'h3: return nvsc_pkg::SEQ_A3[14:2];
      default: return nvsc_pkg::SEQ_A4[14:2];
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////
  // delivery state, power-up restore
  initial begin
    pls_en = 1'b1;
    busy_n = 1'b0;
    foreach (nv[i]) nv[i] = 8'h00;
    foreach (sram[i]) sram[i] = nv[i];
    #(T_REST) busy_n = 1'b1;
  end
  // idle or hi-z shows inverted data
  assign dout = (io_on && !ce_n && !oe_n && we_n && busy_n && pend == 2'h0) ?
                sram[addr] : ~sram[addr];
  // write aborts a sequence, blocked when busy
  always @(posedge we_n) begin
    if (!ce_n && busy_n && io_on) begin
      sram[addr] = din;
      idx = 3'h0;
    end
  end
  always @(negedge oe_n) begin
    if (!ce_n && we_n && busy_n) begin
      m = addr[14:2];
      if (idx == 3'h5) begin
        idx = (m == sq(3'h0)) ? 3'h1 : 3'h0;
        if (m == nvsc_pkg::SEQ_SAVE[14:2]) pend = 2'h1;
        if (m == nvsc_pkg::SEQ_REST[14:2]) pend = 2'h2;
        // the two setting codes share bits 14..2, so only these two use the full address
        // power-loss save setting
        if (addr == nvsc_pkg::SEQ_PLS_OFF) pls_en = 1'b0;
        if (addr == nvsc_pkg::SEQ_PLS_ON) pls_en = 1'b1;
      end else begin
        idx = (m == sq(idx)) ? idx + 3'h1 : (m == sq(3'h0)) ? 3'h1 : 3'h0;
      end
    end
  end
  always @(posedge oe_n) begin
    if (pend != 2'h0) begin
      busy_n = 1'b0;
      // a software save runs whether or not a write came first
      if (pend == 2'h1) begin
        foreach (nv[i]) nv[i] = 8'hFF;
        foreach (nv[i]) nv[i] = sram[i];
        #(T_SAVE);
      end else begin
        foreach (sram[i]) sram[i] = 8'h00;
        foreach (sram[i]) sram[i] = nv[i];
        #(T_REST);
      end
      pend = 2'h0;
      busy_n = 1'b1;
    end
  end
endmodule

// *** dv/tb_nv_sram_sequence_controller.sv ***
// self-checking bench for the host sequence controller
`timescale 1ns/1ps
module tb_nv_sram_sequence_controller;
  logic                clk = 1'b0;
  logic                arst_n = 1'b0;
  logic                req_valid = 1'b0;
  nvsc_pkg::nvsc_req_s req = '0;
  logic                req_ready, rsp_valid, pend, ce_n, oe_n, we_n, dq_oe, busy_n, pls_en;
  logic [7:0]          rsp_rdata, dq_out, dev_dq, bus, rd;
  logic [14:0]         addr;
  int                  n_mismatch = 0;
  int                  compares = 0;
  assign bus = dq_oe ? dq_out : dev_dq;
  initial forever #20 clk = ~clk;
  nvsc_host DUT (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .pls_change_pending(pend), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(bus), .store_busy_n_in(busy_n));
  nvsc_dev_model dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .din(bus),
    .dout(dev_dq), .busy_n(busy_n), .pls_en(pls_en));
  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // entered at a falling edge; bounded waits on ready and response
  task automatic op(input nvsc_pkg::nvsc_cmd_e c, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    req_valid = 1'b1;
    req = '{cmd: c, addr: a, wdata: d};
    while (req_ready !== 1'b1 && n < 5000) begin @(negedge clk); n++; end
    @(negedge clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 5000) begin @(negedge clk); n++; end
    if (n >= 5000) n_mismatch++;
    rd = rsp_rdata;
  endtask
  task automatic t_rw();
    op(nvsc_pkg::NVSC_CMD_WRITE, 15'h1234, 8'hA5);
    op(nvsc_pkg::NVSC_CMD_READ, 15'h1234, 8'h00);
    check("read back", rd, 8'hA5);
    op(nvsc_pkg::NVSC_CMD_READ, 15'h7FFF, 8'h00);
    check("delivered cell", rd, 8'h00);
  endtask
  task automatic t_save_restore();
    op(nvsc_pkg::NVSC_CMD_WRITE, 15'h0010, 8'h5A);
    op(nvsc_pkg::NVSC_CMD_SAVE, 15'h0000, 8'h00);
    op(nvsc_pkg::NVSC_CMD_WRITE, 15'h0010, 8'hC3);
    op(nvsc_pkg::NVSC_CMD_READ, 15'h0010, 8'h00);
    check("after save", rd, 8'hC3);
    op(nvsc_pkg::NVSC_CMD_RESTORE, 15'h0000, 8'h00);
    op(nvsc_pkg::NVSC_CMD_READ, 15'h0010, 8'h00);
    check("restored cell", rd, 8'h5A);
    op(nvsc_pkg::NVSC_CMD_READ, 15'h1234, 8'h00);
    check("saved cell", rd, 8'hA5);
  endtask
  task automatic t_pls();
    op(nvsc_pkg::NVSC_CMD_PLS_OFF, 15'h0000, 8'h00);
    check("setting off", {7'h0, pls_en}, 8'h00);
    check("change flag", {7'h0, pend}, 8'h01);
    op(nvsc_pkg::NVSC_CMD_SAVE, 15'h0000, 8'h00);
    check("flag cleared", {7'h0, pend}, 8'h00);
    op(nvsc_pkg::NVSC_CMD_PLS_ON, 15'h0000, 8'h00);
    check("setting on", {7'h0, pls_en}, 8'h01);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    t_rw();
    t_save_restore();
    t_pls();
    tally_and_finish();
  end
  // thirteen operations plus three transfers need far less than this
  initial begin
    #(40 * 60000);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
